// ==== rtl/cmpsel_regs.svh ====
// register offsets, reset values and field positions of the comparator input routing block
// assumes inclusion from the top module only
`ifndef CMPSEL_REGS_SVH
`define CMPSEL_REGS_SVH
`define CMPSEL_PAGE            8'h00
`define CMPSEL_CMP0_ADDR       8'h9C
`define CMPSEL_CMP1_ADDR       8'h9F
`define CMPSEL_ROUTING_RESET   8'h77
`define CMPSEL_NEG_MSB         7
`define CMPSEL_NEG_LSB         4
`define CMPSEL_POS_MSB         3
`define CMPSEL_POS_LSB         0
`define CMPSEL_LAST_PIN_CODE   4'hB
`endif

// ==== rtl/cmpsel_pkg.sv ====
// types shared by the comparator input routing block
// assumes the register header is on the include path
package cmpsel_pkg;
	typedef logic [3:0] cmpsel_code_t;
	typedef logic [7:0] cmpsel_byte_t;
endpackage : cmpsel_pkg

// ==== rtl/cmpsel_decode.sv ====
// one selector decoder: 4-bit code to a one-hot pin choice among twelve pins
// assumes the code is the next register value, with the pick registered after decoding on the same clock
`timescale 1ns/1ps
`default_nettype none
module cmpsel_decode
	import cmpsel_pkg::*;
(
	input  wire cmpsel_pkg::cmpsel_code_t code,
	output logic [11:0]                  pick
);
	// codes above the last pin code leave every switch open
	genvar i;
	generate
		for (i = 0; i < 12; i++)
		begin : g_pick
			assign pick[i] = (code == 4'(i));
		end
	endgenerate
endmodule : cmpsel_decode
`default_nettype wire

// ==== rtl/cmpsel_top.sv ====
// comparator input routing: two routing registers on the special-function bus
// and one-hot switch enables for each comparator input
// assumes a single-cycle sfr bus with page select, reads combinational into a registered bus
//
// Operation
// - negative codes pick odd pins, upper codes none
// - positive codes pick even pins, upper codes none
// - comparator0 register at 0x9C page 0
// - comparator1 register at 0x9F, same layout
// - reset loads 0111 into every selector
// - both multiplexers may share any pin
`timescale 1ns/1ps
`default_nettype none
`include "cmpsel_regs.svh"
module cmpsel_top
	import cmpsel_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	input  wire cmpsel_pkg::cmpsel_byte_t sfr_addr,
	input  wire cmpsel_pkg::cmpsel_byte_t sfr_page,
	input  wire logic                 sfr_wr,
	input  wire logic                 sfr_rd,
	input  wire cmpsel_pkg::cmpsel_byte_t sfr_wdata,
	output logic [7:0]                sfr_rdata,
	output logic                      sfr_rsel,
	output logic [11:0]               cmp0_neg_pick,
	output logic [11:0]               cmp0_pos_pick,
	output logic [11:0]               cmp1_neg_pick,
	output logic [11:0]               cmp1_pos_pick
);
	import cmpsel_pkg::*;

	cmpsel_byte_t comparator0_input_routing_q;
	cmpsel_byte_t comparator0_input_routing_d;
	cmpsel_byte_t comparator1_input_routing_q;
	cmpsel_byte_t comparator1_input_routing_d;
	logic [7:0]   rdata_q;
	logic [7:0]   rdata_d;
	logic         rsel_q;
	logic         rsel_d;
	logic [11:0]  n0_q, n0_d, p0_q, p0_d, n1_q, n1_d, p1_q, p1_d;
	logic         hit0;
	logic         hit1;

	cmpsel_code_t cmp0_negative_selector;
	cmpsel_code_t cmp0_positive_selector;
	cmpsel_code_t cmp1_negative_selector;
	cmpsel_code_t cmp1_positive_selector;

	assign hit0 = (sfr_page == `CMPSEL_PAGE) && (sfr_addr == `CMPSEL_CMP0_ADDR);
	assign hit1 = (sfr_page == `CMPSEL_PAGE) && (sfr_addr == `CMPSEL_CMP1_ADDR);

	// selectors taken from the next register value so the registered pick
	// changes on the same edge as the register, one cycle after the write
	assign cmp0_negative_selector = comparator0_input_routing_d[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
	assign cmp0_positive_selector = comparator0_input_routing_d[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];
	assign cmp1_negative_selector = comparator1_input_routing_d[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
	assign cmp1_positive_selector = comparator1_input_routing_d[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];

	// separate decoders per comparator: no pin is ever locked out by the other side
	cmpsel_decode u_n0 (.code(cmp0_negative_selector), .pick(n0_d));
	cmpsel_decode u_p0 (.code(cmp0_positive_selector), .pick(p0_d));
	cmpsel_decode u_n1 (.code(cmp1_negative_selector), .pick(n1_d));
	cmpsel_decode u_p1 (.code(cmp1_positive_selector), .pick(p1_d));

	always_comb
	begin
		comparator0_input_routing_d = comparator0_input_routing_q;
		comparator1_input_routing_d = comparator1_input_routing_q;
		rdata_d = 8'h00;
		rsel_d  = 1'b0;
		if (sfr_wr && hit0)
		begin
			comparator0_input_routing_d = sfr_wdata;
		end
		else if (sfr_wr && hit1)
		begin
			comparator1_input_routing_d = sfr_wdata;
		end
		if (sfr_rd && hit0)
		begin
			rdata_d = comparator0_input_routing_q;
			rsel_d  = 1'b1;
		end
		else if (sfr_rd && hit1)
		begin
			rdata_d = comparator1_input_routing_q;
			rsel_d  = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			comparator0_input_routing_q <= `CMPSEL_ROUTING_RESET;
			comparator1_input_routing_q <= `CMPSEL_ROUTING_RESET;
			rdata_q <= 8'h00;
			rsel_q  <= 1'b0;
			// code 0111 selects pin index 7 on each input
			n0_q <= 12'h080;
			p0_q <= 12'h080;
			n1_q <= 12'h080;
			p1_q <= 12'h080;
		end
		else
		begin
			comparator0_input_routing_q <= comparator0_input_routing_d;
			comparator1_input_routing_q <= comparator1_input_routing_d;
			rdata_q <= rdata_d;
			rsel_q  <= rsel_d;
			n0_q <= n0_d;
			p0_q <= p0_d;
			n1_q <= n1_d;
			p1_q <= p1_d;
		end
	end

	assign sfr_rdata     = rdata_q;
	assign sfr_rsel      = rsel_q;
	assign cmp0_neg_pick = n0_q;
	assign cmp0_pos_pick = p0_q;
	assign cmp1_neg_pick = n1_q;
	assign cmp1_pos_pick = p1_q;
endmodule : cmpsel_top
`default_nettype wire

// ==== verif/cmpsel_checker.sv ====
// checker: register and pick relations seen at the top ports
// assumes a single clock and sync reset on the top module
`timescale 1ns/1ps
`default_nettype none
module cmpsel_checker(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic [7:0]  sfr_addr,
	input wire logic [7:0]  sfr_page,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        sfr_rsel,
	input wire logic [11:0] cmp0_neg_pick,
	input wire logic [11:0] cmp1_pos_pick
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	function automatic logic [11:0] pk(input logic [3:0] c);
		return (c < 4'hc) ? 12'h001 << c : 12'h000;
	endfunction : pk
	sequence s_wr0; sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h9c; endsequence
	sequence s_rd0; sfr_rd && sfr_page == 8'h00 && sfr_addr == 8'h9c; endsequence
	property p_rst; $fell(rst) |-> cmp0_neg_pick == 12'h080 && cmp1_pos_pick == 12'h080; endproperty
	a_rst: assert property (p_rst) else $error("pick not at reset");
	property p_hit;
		sfr_rd && sfr_page == 8'h00 && (sfr_addr == 8'h9c || sfr_addr == 8'h9f) |=> sfr_rsel;
	endproperty
	a_hit: assert property (p_hit) else $error("read not answered");
	property p_miss; sfr_rd && sfr_page != 8'h00 |=> !sfr_rsel && sfr_rdata == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("page miss answered");
	property p_neg; s_wr0 |=> cmp0_neg_pick == pk($past(sfr_wdata[7:4])); endproperty
	a_neg: assert property (p_neg) else $error("bad negative pick");
	property p_pos;
		sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h9f |=> cmp1_pos_pick == pk($past(sfr_wdata[3:0]));
	endproperty
	a_pos: assert property (p_pos) else $error("bad positive pick");
	property p_back; s_wr0 ##1 !sfr_wr ##1 s_rd0 |=> sfr_rdata == $past(sfr_wdata, 3); endproperty
	a_back: assert property (p_back) else $error("read back differs");
	property p_keep;
		!(sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'h9c) |=> $stable(cmp0_neg_pick);
	endproperty
	a_keep: assert property (p_keep) else $error("pick moved");
endmodule : cmpsel_checker
bind cmpsel_top cmpsel_checker i_chk (.*);
`default_nettype wire

// ==== verif/cmpsel_pins.sv ====
// pin side model: turns a one-hot pick into port*8+bit
`timescale 1ns/1ps
`default_nettype none
module cmpsel_pins(
	input  wire logic [11:0] pick,
	input  wire logic        odd,
	output logic [4:0]       pin_id,
	output logic             linked
);
	always_comb
	begin
		pin_id = 5'h1f;
		linked = 1'b0;
		for (int k = 0; k < 12; k++)
			if (pick[k])
			begin
				pin_id = 5'(k / 4 * 8 + k % 4 * 2 + odd);
				linked = 1'b1;
			end
	end
endmodule : cmpsel_pins
`default_nettype wire

// ==== verif/tb_comparator_input_select.sv ====
// testbench: sfr bus stimulus, routing and read back judged here
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_input_select;
	import cmpsel_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, sfr_rsel, ln;
	cmpsel_byte_t sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [11:0] cmp0_neg_pick, cmp0_pos_pick, cmp1_neg_pick, cmp1_pos_pick, rd_q;
	logic [4:0] pin;
	int num_errors = 0, cmp_count = 0;
	always #12.5 ref_clk = ~ref_clk;
	cmpsel_top i_dut (.*);
	cmpsel_pins i_pins (.pick(cmp0_neg_pick), .odd(1'b1), .pin_id(pin), .linked(ln));
	task automatic chk(input logic [11:0] got, exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input cmpsel_byte_t a, pg, d);
		@(posedge ref_clk);
		sfr_wr <= w;
		sfr_rd <= !w;
		sfr_addr <= a;
		sfr_page <= pg;
		sfr_wdata <= d;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		sfr_rd <= 1'b0;
		#1 rd_q = {3'h0, sfr_rsel, sfr_rdata};
	endtask : bus
	task automatic t_reset;
		bus(0, 8'h9c, 8'h00, 8'h00);
		chk(rd_q, 12'h177);
		bus(0, 8'h9f, 8'h00, 8'h00);
		chk(rd_q, 12'h177);
		chk(pin, 12'h00f);
		chk(cmp0_pos_pick, 12'h080);
		chk(cmp1_neg_pick, 12'h080);
		chk(cmp1_pos_pick, 12'h080);
	endtask : t_reset
	task automatic t_codes;
		for (int c = 0; c < 16; c++)
		begin
			bus(1, 8'h9c, 8'h00, {c[3:0], c[3:0]});
			bus(1, 8'h9f, 8'h00, {c[3:0], c[3:0]});
			chk(ln ? pin : 12'hfff, c < 12 ? 12'(c / 4 * 8 + c % 4 * 2 + 1) : 12'hfff);
			chk(cmp0_pos_pick, c < 12 ? 12'h001 << c : 12'h000);
			chk(cmp1_neg_pick, c < 12 ? 12'h001 << c : 12'h000);
			chk(cmp1_pos_pick, c < 12 ? 12'h001 << c : 12'h000);
		end
	endtask : t_codes
	task automatic t_back;
		bus(1, 8'h9c, 8'h00, 8'ha5);
		bus(0, 8'h9c, 8'h00, 8'h00);
		chk(rd_q, 12'h1a5);
		bus(1, 8'h9c, 8'h01, 8'h3c);
		bus(0, 8'h9c, 8'h01, 8'h00);
		chk(rd_q, 12'h000);
		bus(0, 8'h9f, 8'h00, 8'h00);
		chk(rd_q, 12'h1ff);
		bus(0, 8'h9c, 8'h00, 8'h00);
		chk(rd_q, 12'h1a5);
	endtask : t_back
	task automatic finish_test;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_codes();
		t_back();
		finish_test();
	end
endmodule : tb_comparator_input_select
`default_nettype wire
